// >>> logic/dwl_params.svh
// Constants for the write leveling and calibration pattern block.
// Assumes inclusion by logic/dwl_pkg.sv and the design module only.
`ifndef DWL_PARAMS_SVH
`define DWL_PARAMS_SVH

// ----------------------------------------------------------------
// Mode register fields (address bit positions)
// ----------------------------------------------------------------
`define DWL_LVL_EN_BIT 7
`define DWL_QOFF_BIT 12
`define DWL_PAT_EN_BIT 2
`define DWL_BURST_OTF_BIT 0
`define DWL_BURST_CHOP_BIT 12
`define DWL_NIBBLE_BIT 2

// ----------------------------------------------------------------
// Register map (byte addresses on the register bus)
// ----------------------------------------------------------------
`define DWL_REG_CTRL 8'h00
`define DWL_REG_STAT 8'h04
`define DWL_REG_LVL 8'h08
`define DWL_REG_PAT 8'h0C

// ----------------------------------------------------------------
// Reset values, timing and calibration pattern words
// ----------------------------------------------------------------
`define DWL_CTRL_RESET 32'h0000_0000
`define DWL_MODE_UPDATE_NS 15
`define DWL_LVL_OUT_NS 9
`define DWL_CLK_NS 25
`define DWL_MODE_UPDATE_CYC (((`DWL_MODE_UPDATE_NS) + (`DWL_CLK_NS) - 1) / (`DWL_CLK_NS))
`define DWL_LVL_OUT_CYC (((`DWL_LVL_OUT_NS) / (`DWL_CLK_NS)) < 1 ? 1 : ((`DWL_LVL_OUT_NS) / (`DWL_CLK_NS)))
`define DWL_PATTERN_LOC0 8'hAA
`define DWL_PATTERN_RSVD 8'h00

`endif

// >>> logic/dwl_pkg.sv
// Types shared by the write leveling and calibration pattern block.
// Assumes dwl_params.svh is on the include path.
`include "dwl_params.svh"

package dwl_pkg;

    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_MODE_SET = 3'b001,
        CMD_READ = 3'b010,
        CMD_READ_AP = 3'b011,
        CMD_WRITE = 3'b100,
        CMD_OTHER = 3'b101
    } dwl_cmd_t;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_LEVEL = 2'b01,
        ST_PATTERN = 2'b10
    } dwl_mode_t;

    typedef struct packed {
        dwl_mode_t mode;
        logic [15:0] lvl_reg;
        logic [15:0] pat_reg;
        logic [15:0] burst_reg;
        logic [7:0] upd_cnt;
        logic odt_ok;
        logic sampled_once;
        logic fb_level;
        logic [7:0] fb_cnt;
        logic fb_out;
        logic [7:0] rl_cnt;
        logic rd_pend;
        logic [7:0] rd_word;
        logic [2:0] rd_pos;
        logic [3:0] rd_left;
        logic [7:0] dq_o;
        logic dq_oe;
        logic dqs_term;
        logic undef_dq;
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic rvalid;
        logic bvalid;
        logic [1:0] rresp;
        logic [1:0] bresp;
        logic protocol_err;
        logic aw_hold;
        logic w_hold;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [1:0] dqs_sync;
        logic dqs_prev;
        logic [1:0] ck_sync;
        logic [1:0] odt_sync;
    } dwl_state_t;

endpackage

// >>> logic/dwl_core.sv
// Write leveling feedback and calibration pattern readout of the memory device.
// Assumes commands arrive decoded on the device clock and strobe/clock/termination pins are asynchronous.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "dwl_params.svh"

module dwl_core
    import dwl_pkg::*;
#(
    parameter int unsigned READ_LATENCY = 6,
    parameter bit FEEDBACK_ALL = 1'b0
) (
    input wire logic ref_clk, // Device clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire dwl_cmd_t cmd, // Decoded command, one cycle.
    input wire logic [1:0] cmd_reg_sel, // Mode register selected by a mode-set.
    input wire logic [15:0] cmd_addr, // Address bits of the command.
    input wire logic dqs_in, // Strobe pin.
    input wire logic ck_level, // Differential clock level as a pin input.
    input wire logic odt_in, // Termination pin.
    output logic [7:0] dq_o, // Data pin output value.
    output logic dq_oe, // Data pin output enable.
    output logic dq_undefined, // Data pins are in undefined drive state.
    output logic dqs_term_on, // Strobe-pair termination applied.
    output logic dq_term_on, // Data termination applied.
    output logic precharge_req, // Auto precharge request to the array.
    output logic array_access, // Read or write goes to the array.
    output logic cmd_illegal, // Pulse: forbidden command seen.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready // Read data ready.
);

    localparam logic [7:0] MODE_UPD = 8'(`DWL_MODE_UPDATE_CYC);
    localparam logic [7:0] LVL_OUT = 8'(`DWL_LVL_OUT_CYC);
    localparam logic [7:0] RL = 8'(READ_LATENCY);
    localparam logic [1:0] SEL_BURST = 2'h0;
    localparam logic [1:0] SEL_LVL = 2'h1;
    localparam logic [1:0] SEL_PAT = 2'h3;

    dwl_state_t q, d;
    logic dqs_rise;
    logic is_read;
    logic chop;
    logic [7:0] pat_word;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        dqs_rise = q.dqs_sync[1] && !q.dqs_prev;
        is_read = (cmd == CMD_READ) || (cmd == CMD_READ_AP);
        cmd_illegal = 1'b0;
        d.dqs_sync = {q.dqs_sync[0], dqs_in};
        d.dqs_prev = q.dqs_sync[1];
        d.ck_sync = {q.ck_sync[0], ck_level};
        d.odt_sync = {q.odt_sync[0], odt_in};
        if (q.upd_cnt != 8'h00) begin
            d.upd_cnt = q.upd_cnt - 8'h01;
        end
        if (q.mode == ST_LEVEL && q.upd_cnt == 8'h01) begin
            d.odt_ok = 1'b1;
        end
        if (q.mode == ST_NORMAL && q.upd_cnt == 8'h01) begin
            d.undef_dq = 1'b0;
        end
        // Mode-set handling.
        if (cmd == CMD_MODE_SET) begin
            if (cmd_reg_sel == SEL_LVL) begin
                if (q.mode == ST_PATTERN) begin
                    cmd_illegal = 1'b1;
                end else begin
                    d.lvl_reg = cmd_addr;
                    d.upd_cnt = MODE_UPD;
                    if (cmd_addr[`DWL_LVL_EN_BIT]) begin
                        if (q.mode == ST_NORMAL) begin
                            d.mode = ST_LEVEL;
                            d.odt_ok = 1'b0;
                            d.sampled_once = 1'b0;
                            d.undef_dq = 1'b1;
                        end
                    end else begin
                        d.mode = ST_NORMAL;
                        d.odt_ok = 1'b0;
                        d.undef_dq = (q.mode == ST_LEVEL) || q.undef_dq;
                    end
                end
            end else if (cmd_reg_sel == SEL_PAT && q.mode != ST_LEVEL) begin
                d.pat_reg = cmd_addr;
                d.mode = cmd_addr[`DWL_PAT_EN_BIT] ? ST_PATTERN : ST_NORMAL;
            end else if (cmd_reg_sel == SEL_BURST && q.mode == ST_NORMAL) begin
                d.burst_reg = cmd_addr;
            end else begin
                cmd_illegal = 1'b1;
            end
        end else if (cmd != CMD_NOP) begin
            if (q.mode == ST_LEVEL || (q.mode == ST_PATTERN && !is_read)) begin
                cmd_illegal = 1'b1;
            end
        end
        // Leveling: sample clock on each rising strobe.
        if (q.mode == ST_LEVEL) begin
            if (dqs_rise) begin
                d.fb_level = q.ck_sync[1];
                d.fb_cnt = LVL_OUT;
                d.sampled_once = 1'b1;
                d.undef_dq = 1'b0;
            end else if (q.fb_cnt != 8'h00) begin
                d.fb_cnt = q.fb_cnt - 8'h01;
                if (q.fb_cnt == 8'h01) begin
                    d.fb_out = q.fb_level;
                end
            end
            if (q.sampled_once) begin
                d.dq_o = FEEDBACK_ALL ? {8{d.fb_out}} : {7'h00, d.fb_out};
            end
            d.dq_oe = 1'b1;
            d.dqs_term = q.odt_ok && q.odt_sync[1];
        end else begin
            d.dqs_term = q.odt_sync[1];
            // The burst logic below raises the enable on beats only, never while the latency counts.
            d.dq_oe = 1'b0;
        end
        // Pattern read: latency then burst.
        chop = !cmd_addr[`DWL_BURST_CHOP_BIT] && q.burst_reg[`DWL_BURST_OTF_BIT];
        unique case (q.pat_reg[1:0])
            2'b00: pat_word = `DWL_PATTERN_LOC0;
            default: pat_word = `DWL_PATTERN_RSVD;
        endcase
        if (q.mode == ST_PATTERN && is_read) begin
            d.rd_pend = 1'b1;
            d.rl_cnt = RL;
            d.rd_word = pat_word;
            d.rd_pos = (chop && cmd_addr[`DWL_NIBBLE_BIT]) ? 3'd4 : 3'd0;
            d.rd_left = chop ? 4'd4 : 4'd8;
        end else if (q.rd_pend) begin
            d.rl_cnt = q.rl_cnt - 8'h01;
            if (q.rl_cnt == 8'h01) begin
                d.rd_pend = 1'b0;
            end
        end
        if (!q.rd_pend && q.rd_left != 4'h0 && q.mode != ST_LEVEL) begin
            d.dq_o = FEEDBACK_ALL ? {8{q.rd_word[q.rd_pos]}} : {7'h00, q.rd_word[q.rd_pos]};
            d.dq_oe = 1'b1;
            d.rd_pos = q.rd_pos + 3'd1;
            d.rd_left = q.rd_left - 4'h1;
        end
        if (cmd_illegal) begin
            d.protocol_err = 1'b1;
        end
        // Register bus.
        if (s_axi_awvalid && !q.aw_hold) begin
            d.aw_hold = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_hold) begin
            d.w_hold = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.aw_hold && q.w_hold && !q.bvalid) begin
            d.aw_hold = 1'b0;
            d.w_hold = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'b00;
            if (q.aw_addr == `DWL_REG_CTRL) begin
                for (int i = 0; i < 4; i++) begin
                    if (q.w_strb[i]) begin
                        d.ctrl[i*8 +: 8] = q.w_data[i*8 +: 8];
                    end
                end
            end else if (q.aw_addr == `DWL_REG_STAT) begin
                if (q.w_strb[0] && q.w_data[0] && !cmd_illegal) begin
                    d.protocol_err = 1'b0;
                end
            end else if (q.aw_addr != `DWL_REG_LVL && q.aw_addr != `DWL_REG_PAT) begin
                d.bresp = 2'b10;
            end
        end else if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = 2'b00;
            unique case (s_axi_araddr)
                `DWL_REG_CTRL: d.rdata = q.ctrl;
                `DWL_REG_STAT: d.rdata = {24'h00_0000, q.fb_out, q.undef_dq, q.odt_ok, q.dqs_term,
                                          q.rd_pend, q.mode, q.protocol_err};
                `DWL_REG_LVL: d.rdata = {16'h0000, q.lvl_reg};
                `DWL_REG_PAT: d.rdata = {16'h0000, q.pat_reg};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = 2'b10;
                end
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign dq_o = q.dq_o;
    assign dq_oe = q.dq_oe && !q.ctrl[0];
    assign dq_undefined = q.undef_dq;
    assign dqs_term_on = q.dqs_term;
    assign dq_term_on = (q.mode != ST_LEVEL) && q.odt_sync[1] && q.ctrl[1];
    assign precharge_req = (cmd == CMD_READ_AP) && (q.mode == ST_NORMAL);
    assign array_access = (cmd == CMD_READ || cmd == CMD_READ_AP || cmd == CMD_WRITE)
                          && (q.mode == ST_NORMAL);
    assign s_axi_awready = !q.aw_hold;
    assign s_axi_wready = !q.w_hold;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------------
    // Leveling and protocol error checks
    // ----------------------------------------------------------------
    AST_LVL_ENTER: assert property (
        cmd == CMD_MODE_SET && cmd_reg_sel == SEL_LVL && cmd_addr[7] && q.mode == ST_NORMAL |=> q.mode == ST_LEVEL)
        else $error("leveling not entered");
    AST_DQ_TERM_OFF: assert property (
        q.mode == ST_LEVEL |-> !dq_term_on)
        else $error("data termination on in leveling");
    AST_ODT_WAIT: assert property (
        $rose(q.mode == ST_LEVEL) |-> !q.dqs_term [*1] ##0 !q.odt_ok)
        else $error("termination accepted early");
    AST_FB_DELAY: assert property (
        q.mode == ST_LEVEL && dqs_rise ##1 q.mode == ST_LEVEL |-> ##1 q.fb_out == $past(q.fb_level))
        else $error("feedback timing wrong");
    AST_PRIME_LOW: assert property (
        q.mode == ST_LEVEL && q.sampled_once && !FEEDBACK_ALL |-> q.dq_o[7:1] == 7'h00 || $past(q.mode) != ST_LEVEL)
        else $error("other bits not low");
    AST_UNDEF_EXIT: assert property (
        $fell(q.mode == ST_LEVEL) && q.mode == ST_NORMAL |-> q.undef_dq)
        else $error("data not undefined after exit");
    AST_LVL_ILLEGAL: assert property (
        q.mode == ST_LEVEL && cmd == CMD_OTHER |-> cmd_illegal)
        else $error("foreign command in leveling not flagged");
    AST_ERR_SET: assert property (
        cmd_illegal |=> q.protocol_err)
        else $error("protocol error flag not set");

    // ----------------------------------------------------------------
    // Pattern readout checks
    // ----------------------------------------------------------------
    AST_NO_PRECHARGE: assert property (
        q.mode == ST_PATTERN |-> !precharge_req && !array_access)
        else $error("array touched in pattern mode");
    AST_READ_LAT: assert property (
        q.mode == ST_PATTERN && is_read && !q.rd_pend && q.rd_left == 4'h0 |=> q.rd_pend ##0 q.rl_cnt == RL)
        else $error("read latency not loaded");
    AST_ILLEGAL: assert property (
        q.mode == ST_PATTERN && cmd == CMD_WRITE |-> cmd_illegal)
        else $error("write in pattern mode not flagged");
    AST_LOC0_WORD: assert property (
        q.mode == ST_PATTERN && is_read && q.pat_reg[1:0] == 2'b00 |=> q.rd_word == `DWL_PATTERN_LOC0)
        else $error("calibration word wrong");
    AST_RSVD_WORD: assert property (
        q.mode == ST_PATTERN && is_read && q.pat_reg[1:0] != 2'b00 |=> q.rd_word == `DWL_PATTERN_RSVD)
        else $error("reserved location not zero");
    AST_CHOP_LEN: assert property (
        q.mode == ST_PATTERN && is_read && chop && !q.rd_pend && q.rd_left == 4'h0 |=> q.rd_left == 4'd4)
        else $error("chopped burst length wrong");
    AST_DQ_UPPER: assert property (
        q.dq_oe && q.mode != ST_LEVEL && !FEEDBACK_ALL |-> q.dq_o[7:1] == 7'h00)
        else $error("upper data bits not low");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------
    COV_LEVEL: cover property (q.mode == ST_LEVEL && dqs_rise);
    COV_PATTERN: cover property (q.mode == ST_PATTERN && is_read);
    COV_CHOP: cover property (q.mode == ST_PATTERN && is_read && chop);
    COV_EXIT: cover property ($fell(q.mode == ST_LEVEL));
    COV_RSVD: cover property (q.mode == ST_PATTERN && is_read && q.pat_reg[1:0] != 2'b00);

endmodule
`default_nettype wire

// >>> testbench/dwl_ctrl_model.sv
// Memory controller model: commands, strobe, clock level and termination pin.
// Assumes the device samples every output on the rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none

module dwl_ctrl_model
    import dwl_pkg::*;
(
    input wire logic ref_clk, // Device clock.
    output var dwl_cmd_t cmd, // Decoded command.
    output logic [1:0] cmd_reg_sel, // Mode register target.
    output logic [15:0] cmd_addr, // Command address.
    output logic dqs_in, // Strobe pin.
    output logic ck_level, // Clock level seen at the device.
    output logic odt_in // Termination pin.
);
    initial begin
        cmd = CMD_NOP;
        cmd_reg_sel = 2'h0;
        cmd_addr = 16'h0000;
        dqs_in = 1'b0;
        ck_level = 1'b0;
        odt_in = 1'b0;
    end

    // Only no-ops separate mode-sets and reads.
    task automatic drive(input dwl_cmd_t c, input logic [1:0] s, input logic [15:0] a);
        @(posedge ref_clk);
        cmd <= c;
        cmd_reg_sel <= s;
        cmd_addr <= a;
    endtask

    task automatic issue(input dwl_cmd_t c, input logic [1:0] s, input logic [15:0] a);
        drive(c, s, a);
        drive(CMD_NOP, 2'h0, 16'h0000);
    endtask

    // Strobe parked low for gap cycles, then one rising edge.
    task automatic strobe(input logic lvl, input int gap);
        @(posedge ref_clk);
        ck_level <= lvl;
        dqs_in <= 1'b0;
        repeat (gap) @(posedge ref_clk);
        dqs_in <= 1'b1;
        repeat (3) @(posedge ref_clk);
        dqs_in <= 1'b0;
    endtask

    // Termination raised only after the mode update delay, dropped before exit.
    task automatic term(input logic on);
        @(posedge ref_clk);
        odt_in <= on;
    endtask
endmodule

`default_nettype wire

// >>> testbench/test_dwl_core.sv
// Self-checking bench for dwl_core: leveling feedback, pattern reads, register bus.
// Assumes dwl_pkg and dwl_ctrl_model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module test_dwl_core
    import dwl_pkg::*;
;
    localparam int RL = 4;
    typedef struct packed {
        dwl_cmd_t c;
        logic [1:0] loc;
        logic [15:0] a;
        logic [7:0] word;
        logic [3:0] beats;
    } dwl_row_t;
    localparam dwl_row_t ROWS [7] = '{
        '{CMD_READ, 2'h0, 16'h1000, 8'hAA, 4'h8},
        '{CMD_READ_AP, 2'h0, 16'h3FF8, 8'hAA, 4'h8},
        '{CMD_READ, 2'h0, 16'h0000, 8'hAA, 4'h4},
        '{CMD_READ, 2'h0, 16'h0004, 8'hAA, 4'h4},
        '{CMD_READ, 2'h1, 16'h1000, 8'h00, 4'h8},
        '{CMD_READ, 2'h2, 16'h1000, 8'h00, 4'h8},
        '{CMD_READ, 2'h3, 16'h0004, 8'h00, 4'h4}};

    logic ref_clk, resetn, dqs_in, ck_level, odt_in;
    dwl_cmd_t cmd;
    logic [1:0] cmd_reg_sel, s_axi_bresp, s_axi_rresp, r;
    logic [15:0] cmd_addr;
    logic [7:0] dq_o, s_axi_awaddr, s_axi_araddr;
    logic dq_oe, dq_undefined, dqs_term_on, dq_term_on, precharge_req, array_access, cmd_illegal;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;

    dwl_core #(.READ_LATENCY(RL), .FEEDBACK_ALL(1'b0)) dwl_core_inst (.ref_clk, .resetn, .cmd, .cmd_reg_sel,
        .cmd_addr, .dqs_in, .ck_level, .odt_in, .dq_o, .dq_oe, .dq_undefined, .dqs_term_on, .dq_term_on,
        .precharge_req, .array_access, .cmd_illegal, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dwl_ctrl_model dwl_ctrl_model_inst (.ref_clk, .cmd, .cmd_reg_sel, .cmd_addr, .dqs_in, .ck_level, .odt_in);

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    task automatic test_done();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Issues one pattern read and follows the burst beat by beat.
    task automatic burst(input dwl_row_t w);
        int n;
        int st;
        n = 0;
        st = (w.beats == 4'h4 && w.a[2]) ? 4 : 0;
        dwl_ctrl_model_inst.issue(w.c, 2'h0, w.a);
        while (dq_oe !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        chk(n >= RL && n <= RL + 3, 1'b1);
        for (int k = 0; k < w.beats; k++) begin
            chk(dq_o[0], w.word[st+k]);
            chk(dq_o[7:1] === 7'h00 || dq_o[7:1] === {7{dq_o[0]}}, 1'b1);
            @(posedge ref_clk);
        end
        chk(dq_oe, 1'b0);
    endtask

    initial begin
        resetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        axi_rd(8'h00, d, r);
        chk(d, 32'h0000_0000);
        axi_rd(8'h04, d, r);
        chk(d, 32'h0000_0000);
        axi_wr(8'h00, 32'h0000_0002, r);
        chk(r, 2'b00);
        axi_rd(8'h00, d, r);
        chk(d, 32'h0000_0002);
        axi_wr(8'h00, 32'h0000_0000, r);
        axi_rd(8'h40, d, r);
        chk({d, r}, 34'h0_0000_0002);
        axi_wr(8'h40, 32'h0000_0001, r);
        chk(r, 2'b10);
        dwl_ctrl_model_inst.issue(CMD_MODE_SET, 2'h1, 16'h0080);
        @(posedge ref_clk);
        chk(dq_undefined, 1'b1);
        axi_rd(8'h04, d, r);
        chk(d[2:1], ST_LEVEL);
        dwl_ctrl_model_inst.term(1'b1);
        repeat (5) @(posedge ref_clk);
        chk({dqs_term_on, dq_term_on}, 2'b10);
        dwl_ctrl_model_inst.strobe(1'b0, 2);
        repeat (8) @(posedge ref_clk);
        chk(dq_o, 8'h00);
        dwl_ctrl_model_inst.strobe(1'b1, 6);
        repeat (8) @(posedge ref_clk);
        chk(dq_o, 8'h01);
        dwl_ctrl_model_inst.drive(CMD_OTHER, 2'h0, 16'h0000);
        #2;
        chk(cmd_illegal, 1'b1);
        dwl_ctrl_model_inst.drive(CMD_NOP, 2'h0, 16'h0000);
        dwl_ctrl_model_inst.term(1'b0);
        repeat (5) @(posedge ref_clk);
        chk({dqs_term_on, dq_term_on}, 2'b00);
        dwl_ctrl_model_inst.issue(CMD_MODE_SET, 2'h1, 16'h1266);
        repeat (3) @(posedge ref_clk);
        axi_rd(8'h08, d, r);
        chk(d[15:0], 16'h1266);
        axi_rd(8'h04, d, r);
        chk(d[2:1], ST_NORMAL);
        dwl_ctrl_model_inst.issue(CMD_MODE_SET, 2'h0, 16'h0001);
        for (int i = 0; i < 7; i++) begin
            dwl_ctrl_model_inst.issue(CMD_MODE_SET, 2'h3, {13'h0000, 1'b1, ROWS[i].loc});
            repeat (2) @(posedge ref_clk);
            burst(ROWS[i]);
        end
        dwl_ctrl_model_inst.drive(CMD_READ_AP, 2'h0, 16'h1400);
        #2;
        chk({precharge_req, array_access}, 2'b00);
        dwl_ctrl_model_inst.drive(CMD_WRITE, 2'h0, 16'h0000);
        #2;
        chk(cmd_illegal, 1'b1);
        dwl_ctrl_model_inst.drive(CMD_NOP, 2'h0, 16'h0000);
        repeat (20) @(posedge ref_clk);
        axi_rd(8'h04, d, r);
        chk(d[0], 1'b1);
        axi_wr(8'h04, 32'h0000_0001, r);
        axi_rd(8'h04, d, r);
        chk(d[0], 1'b0);
        dwl_ctrl_model_inst.issue(CMD_MODE_SET, 2'h3, 16'h0000);
        repeat (3) @(posedge ref_clk);
        dwl_ctrl_model_inst.drive(CMD_READ_AP, 2'h0, 16'h1000);
        #2;
        chk({precharge_req, array_access}, 2'b11);
        dwl_ctrl_model_inst.issue(CMD_MODE_SET, 2'h3, 16'h0004);
        repeat (3) @(posedge ref_clk);
        axi_rd(8'h04, d, r);
        chk(d[2:1], ST_PATTERN);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        axi_rd(8'h04, d, r);
        chk(d[2:1], ST_NORMAL);
        test_done();
    end
endmodule

`default_nettype wire
